// ### xrd_pkg.sv
// Purpose: constants and carrier types for the exchange register datapath
// Assumes: 24-bit one's-complement words, 3-bit modifier
// Notes:   shared by the datapath top and its testbench
package xrd_pkg;
	localparam int WORD_W   = 24;
	localparam int ADDR_W   = 15;
	localparam int BYTE_W   = 8;
	localparam int IO_W     = 7;
	localparam int MOD_W    = 3;
	localparam int BYTE_R_LO = 0;
	localparam int BYTE_C_LO = 8;
	localparam int BYTE_L_LO = 16;
	localparam logic [23:0] WORD_RST = 24'h000000;
	localparam logic [23:0] WORD_ONES = 24'hffffff;
	localparam logic [6:0]  IO_RST   = 7'h00;
	localparam logic [14:0] ADDR_RST = 15'h0000;
	localparam logic [2:0] MOD_FULL  = 3'h0;
	localparam logic [2:0] MOD_RS    = 3'h1;
	localparam logic [2:0] MOD_CS    = 3'h2;
	localparam logic [2:0] MOD_LS    = 3'h3;
	localparam logic [2:0] MOD_ADDR  = 3'h4;
	localparam logic [2:0] MOD_RU    = 3'h5;
	localparam logic [2:0] MOD_CU    = 3'h6;
	localparam logic [2:0] MOD_LU    = 3'h7;

	// one-cycle transfer controls from sequence control
	typedef struct packed {
		logic from_addr;
		logic from_storage;
		logic from_shift_register;
		logic from_accumulator;
		logic from_input_control;
		logic logical_product_control;
		logic to_storage;
		logic to_addr;
		logic to_shift_register_control;
		logic to_output_control;
		logic to_accumulator;
		logic buffer_set;
		logic buffer_negate_control;
	} xrd_ctrl_t;

	// words presented by neighbouring registers
	typedef struct packed {
		logic [23:0] storage;
		logic [14:0] addr;
		logic [23:0] shift_reg;
		logic [23:0] accum;
		logic [6:0]  input_word;
	} xrd_src_t;
endpackage

// ### xrd_datapath.sv
// Purpose: central 24-bit exchange register with complement buffer
// Assumes: controls are one-cycle pulses on clk_sys_i, at most one load at a time
// Notes:   accumulator and adder live outside; this block drives the addend
//
// Functional notes
// [RL1] clear before load, except logical product
// [RL2] address field copies into bits 0-14
// [RL3] modifier 0 loads full storage word
// [RL4] modifiers 1-3 load byte, sign extended
// [RL5] modifier 4 loads 15 bits, no extension
// [RL6] modifiers 5-7 load byte, zero extended
// [RL7] store: modifier 0 full, 4 low 15
// [RL8] store byte into right, center, left
// [RL9] unselected storage bits keep their value
// [RL10] exchange bits 0-14 into address field
// [RL11] buffer copies exchange every cycle; code skips set, negate and post-negate cycles
// [RL12] shift register loads exchange in parallel
// [RL13] logical product clears where shift bit zero
// [RL14] seven low bits go to output
// [RL15] accumulator loads exchange in parallel
// [RL16] seven input bits load low bits
// [RL17] manual set forces each stage one
// [RL18] exchange to shift register via buffer
// [RL19] accumulator reached only through main adder
// [RL20] complement: set buffer, negate where one
// [RL21] one's-complement arithmetic on 24-bit words
// [RL22] adds are modulo two-to-24 minus one
`timescale 1ns/1ps
module xrd_datapath (
	// clock and reset
	input  wire logic                   clk_sys_i,
	input  wire logic                   rst_n_i,
	// transfer controls and modifier
	input  wire xrd_pkg::xrd_ctrl_t     ctrl_i,
	input  wire logic [2:0]             modifier_i,
	// source words
	input  wire xrd_pkg::xrd_src_t      src_i,
	// operator panel
	input  wire logic [23:0]            manual_set_i,
	// exchange and buffer state
	output logic [23:0]                 exchange_o,
	output logic [23:0]                 complement_buffer_o,
	// destinations
	output logic [23:0]                 storage_o,
	output logic                        storage_we_o,
	output logic [14:0]                 addr_o,
	output logic                        addr_we_o,
	output logic [23:0]                 shift_reg_o,
	output logic                        shift_reg_we_o,
	output logic [23:0]                 addend_o,
	output logic                        addend_valid_o,
	output logic [6:0]                  output_word_o,
	output logic                        output_we_o
);
	import xrd_pkg::*;

	logic [23:0] exchange_reg, exchange_next;
	logic [23:0] buffer_reg, buffer_next;
	logic [23:0] storage_reg, storage_next;
	logic [14:0] addr_reg;
	logic [23:0] shift_reg_reg;
	logic [6:0]  output_reg;
	logic        storage_we_reg, addr_we_reg, shift_we_reg, out_we_reg;
	logic        buffer_neg_reg;
	// panel pins cross into the clock domain
	logic [23:0] man_s1_reg, man_s2_reg, man_s3_reg, man_f_reg;
	wire  [23:0] man_f_next;

	// selects byte n (0 right, 1 center, 2 left) of a word
	function automatic logic [7:0] pick_byte(input logic [23:0] w, input logic [1:0] n);
		unique case (n)
			2'd0: pick_byte = w[7:0];
			2'd1: pick_byte = w[15:8];
			default: pick_byte = w[23:16];
		endcase
	endfunction

	wire [1:0] byte_sel = modifier_i[1:0] - 2'd1;
	wire [7:0] st_byte = pick_byte(src_i.storage, byte_sel);

	// [RL3] [RL4] [RL5] [RL6] storage operand shaping
	wire [23:0] storage_operand =
		(modifier_i == MOD_FULL) ? src_i.storage :
		(modifier_i == MOD_ADDR) ? {9'h000, src_i.storage[14:0]} :
		(modifier_i[2])          ? {16'h0000, st_byte} :
		                           {{16{st_byte[7]}}, st_byte};

	// [RL1] [RL2] [RL12] [RL15] [RL16] cleared register then one source
	wire any_load = ctrl_i.from_addr | ctrl_i.from_storage | ctrl_i.from_shift_register |
		ctrl_i.from_accumulator | ctrl_i.from_input_control;
	wire [23:0] load_value =
		ctrl_i.from_addr           ? {9'h000, src_i.addr} :
		ctrl_i.from_storage        ? storage_operand :
		ctrl_i.from_shift_register ? src_i.shift_reg :
		ctrl_i.from_accumulator    ? src_i.accum :
		                             {17'h00000, src_i.input_word};

	// [RL13] logical product keeps contents where shift bit is one
	wire [23:0] product_value = exchange_reg & src_i.shift_reg;

	// [RL17] a bit sets only once stages two and three are both one and clears once either is zero,
	// so a panel pulse to one shorter than two cycles is ignored
	assign man_f_next = (man_s2_reg & man_s3_reg) |
		(man_f_reg & ~(man_s2_reg ^ man_s3_reg));

	// [RL17] manual set ORs over whatever else happens
	assign exchange_next = (ctrl_i.logical_product_control ? product_value :
		any_load ? load_value : exchange_reg) | man_f_reg;

	// [RL11] [RL20] buffer follows exchange; set then negate forms complement
	// hold the ones while the negate pulse is registered, else the copy overwrites them
	assign buffer_next = ctrl_i.buffer_set ? WORD_ONES :
		ctrl_i.buffer_negate_control ? buffer_reg :
		buffer_neg_reg ? (buffer_reg ^ exchange_reg) : exchange_reg;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			man_s1_reg <= WORD_RST;
			man_s2_reg <= WORD_RST;
			man_s3_reg <= WORD_RST;
			man_f_reg  <= WORD_RST;
		end else begin
			man_s1_reg <= manual_set_i;
			man_s2_reg <= man_s1_reg;
			man_s3_reg <= man_s2_reg;
			man_f_reg  <= man_f_next;
		end
	end

	// [RL7] [RL8] [RL9] store field merge, untouched bits retained
	wire [1:0] st_dst = (modifier_i == MOD_RS || modifier_i == MOD_RU) ? 2'd0 :
		(modifier_i == MOD_CS || modifier_i == MOD_CU) ? 2'd1 : 2'd2;
	wire [23:0] byte_merge =
		(st_dst == 2'd0) ? {src_i.storage[23:8], exchange_reg[7:0]} :
		(st_dst == 2'd1) ? {src_i.storage[23:16], exchange_reg[7:0], src_i.storage[7:0]} :
		                   {exchange_reg[7:0], src_i.storage[15:0]};
	assign storage_next =
		(modifier_i == MOD_FULL) ? exchange_reg :
		(modifier_i == MOD_ADDR) ? {src_i.storage[23:15], exchange_reg[14:0]} :
		                           byte_merge;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			exchange_reg   <= WORD_RST;
			buffer_reg     <= WORD_RST;
			buffer_neg_reg <= 1'b0;
		end else begin
			exchange_reg   <= exchange_next;
			buffer_reg     <= buffer_next;
			// negate acts on the cycle after its pulse, while the held buffer is all ones
			buffer_neg_reg <= ctrl_i.buffer_negate_control;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			storage_reg    <= WORD_RST;
			storage_we_reg <= 1'b0;
			addr_reg       <= ADDR_RST;
			addr_we_reg    <= 1'b0;
			shift_reg_reg  <= WORD_RST;
			shift_we_reg   <= 1'b0;
			output_reg     <= IO_RST;
			out_we_reg     <= 1'b0;
		end else begin
			storage_we_reg <= ctrl_i.to_storage;
			addr_we_reg    <= ctrl_i.to_addr;
			shift_we_reg   <= ctrl_i.to_shift_register_control;
			out_we_reg     <= ctrl_i.to_output_control;
			if (ctrl_i.to_storage) begin
				storage_reg <= storage_next;
			end
			// [RL10] low 15 exchange bits to address field
			if (ctrl_i.to_addr) begin
				addr_reg <= exchange_reg[14:0];
			end
			// [RL18] shift register fed from the buffer
			if (ctrl_i.to_shift_register_control) begin
				shift_reg_reg <= buffer_reg;
			end
			// [RL14] seven low bits to output register
			if (ctrl_i.to_output_control) begin
				output_reg <= exchange_reg[6:0];
			end
		end
	end

	// [RL19] [RL21] [RL22] addend offered to the external one's-complement adder only
	assign addend_o       = buffer_reg;
	assign addend_valid_o = ctrl_i.to_accumulator;

	assign exchange_o          = exchange_reg;
	assign complement_buffer_o = buffer_reg;
	assign storage_o           = storage_reg;
	assign storage_we_o        = storage_we_reg;
	assign addr_o              = addr_reg;
	assign addr_we_o           = addr_we_reg;
	assign shift_reg_o         = shift_reg_reg;
	assign shift_reg_we_o      = shift_we_reg;
	assign output_word_o       = output_reg;
	assign output_we_o         = out_we_reg;
endmodule // xrd_datapath

// ### xrd_checker.sv
// Purpose: exchange datapath checks
// Assumes: controls one cycle long
// Notes: bound by module name
`timescale 1ns/1ps
module xrd_checker (
	// inputs
	input wire logic		clk_sys_i,
	input wire logic		rst_n_i,
	input wire xrd_pkg::xrd_ctrl_t	ctrl_i,
	input wire logic [2:0]		modifier_i,
	input wire xrd_pkg::xrd_src_t	src_i,
	input wire logic [23:0]		manual_set_i,
	// outputs
	input wire logic [23:0]		exchange_o,
	input wire logic [23:0]		complement_buffer_o,
	input wire logic [23:0]		storage_o,
	input wire logic		storage_we_o
);
	import xrd_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	wire [23:0] zs = src_i.storage;
	wire [23:0] xs = exchange_o;
	// manual set reaches exchange through a filter; wait until it has drained
	logic [2:0] quiet_cnt;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i)
			quiet_cnt <= 3'h0;
		else if (manual_set_i != 24'h0)
			quiet_cnt <= 3'h0;
		else if (quiet_cnt != 3'h7)
			quiet_cnt <= quiet_cnt + 3'h1;
	end
	wire quiet = quiet_cnt >= 3'h5 && manual_set_i == 24'h0;
	// higher loads and manual set mask the storage path
	wire st_ld = ctrl_i.from_storage && !ctrl_i.from_addr &&
		!ctrl_i.logical_product_control && quiet;
	sequence s_set; ctrl_i.buffer_set; endsequence
	sequence s_neg; ctrl_i.buffer_negate_control && !ctrl_i.buffer_set; endsequence
	property p_full; st_ld && modifier_i == MOD_FULL |=> xs == $past(zs); endproperty
	a_full: assert property (p_full) else $error("full load wrong");
	property p_sext; st_ld && modifier_i == MOD_CS |=>
		xs == {{16{$past(zs[15])}}, $past(zs[15:8])}; endproperty
	a_sext: assert property (p_sext) else $error("signed byte load wrong");
	property p_low; st_ld && modifier_i == MOD_ADDR |=> xs == {9'h0, $past(zs[14:0])}; endproperty
	a_low: assert property (p_low) else $error("field load wrong");
	property p_zext; st_ld && modifier_i == MOD_LU |=> xs == {16'h0, $past(zs[23:16])}; endproperty
	a_zext: assert property (p_zext) else $error("plain byte load wrong");
	property p_lp; ctrl_i.logical_product_control && quiet |=>
		xs == ($past(xs) & $past(src_i.shift_reg)); endproperty
	a_lp: assert property (p_lp) else $error("product wrong");
	property p_buf; !ctrl_i.buffer_set && !ctrl_i.buffer_negate_control &&
		!$past(ctrl_i.buffer_negate_control) |=>
		complement_buffer_o == $past(xs); endproperty
	a_buf: assert property (p_buf) else $error("buffer copy wrong");
	property p_cpl; s_set ##1 s_neg ##1 !ctrl_i.buffer_set |=>
		complement_buffer_o == ~$past(xs); endproperty
	a_cpl: assert property (p_cpl) else $error("complement wrong");
	property p_st; ctrl_i.to_storage && modifier_i == MOD_RU |=> storage_we_o &&
		storage_o == {$past(zs[23:8]), $past(xs[7:0])}; endproperty
	a_st: assert property (p_st) else $error("byte store wrong");
endmodule // xrd_checker
bind xrd_datapath xrd_checker i_xrd_checker (.*);

// ### xrd_nbr.sv
// Purpose: neighbour registers model
// Assumes: storage takes every merged write
// Notes: other words hold the preset
`timescale 1ns/1ps
module xrd_nbr (
	// inputs
	input wire logic		clk_sys_i,
	input wire xrd_pkg::xrd_src_t	preset_i,
	input wire logic		preset_we_i,
	input wire logic [23:0]		storage_i,
	input wire logic		storage_we_i,
	// outputs
	output xrd_pkg::xrd_src_t	src_o
);
	import xrd_pkg::*;
	xrd_src_t src_reg;
	// preset shows at once so sources are defined from time zero
	assign src_o = preset_we_i ? preset_i : src_reg;
	always_ff @(posedge clk_sys_i) begin
		if (preset_we_i)
			src_reg <= preset_i;
		else if (storage_we_i)
			src_reg.storage <= storage_i;
	end
endmodule // xrd_nbr

// ### tb_top.sv
// Purpose: directed bench for the exchange datapath
// Assumes: 20 MHz clock
// Notes: sources come from the neighbour model
`timescale 1ns/1ps
module tb_top;
	import xrd_pkg::*;
	logic		clk_sys_i = 1'b0;
	logic		rst_n_i = 1'b0;
	logic		pre_we = 1'b1;
	logic [2:0]	mdf = 3'h0;
	logic [23:0]	man = 24'h0;
	xrd_ctrl_t	ctrl = '0;
	xrd_src_t	src;
	xrd_src_t	pre = '{24'h7b85e1, 15'h5a3c, 24'h0ff00f, 24'h812345, 7'h55};
	logic [23:0]	xo, bo, so, sh, zv, x;
	logic [14:0]	ao;
	logic [6:0]	oo;
	logic		swe, aw, shw, ow, avld;
	logic [23:0]	add;
	int		miscompares = 0;
	int		check_count = 0;
	always #25 clk_sys_i = ~clk_sys_i;
	xrd_datapath i_xrd_datapath (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl),
		.modifier_i(mdf), .src_i(src), .manual_set_i(man), .exchange_o(xo),
		.complement_buffer_o(bo), .storage_o(so), .storage_we_o(swe), .addr_o(ao),
		.addr_we_o(aw), .shift_reg_o(sh), .shift_reg_we_o(shw), .addend_o(add),
		.addend_valid_o(avld), .output_word_o(oo), .output_we_o(ow));
	xrd_nbr i_xrd_nbr (.clk_sys_i(clk_sys_i), .preset_i(pre), .preset_we_i(pre_we),
		.storage_i(so), .storage_we_i(swe), .src_o(src));
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// k is the control bit, counted up from buffer negate
	task automatic op(input int k, input logic [2:0] m);
		@(posedge clk_sys_i) begin
			ctrl <= xrd_ctrl_t'(13'h1 << k);
			mdf <= m;
		end
		@(posedge clk_sys_i) ctrl <= '0;
		@(negedge clk_sys_i);
	endtask
	// fill with ones first so a missing clear shows
	task automatic ld(input int k, input logic [2:0] m, input logic [23:0] e);
		@(posedge clk_sys_i) man <= WORD_ONES;
		repeat (4) @(posedge clk_sys_i);
		man <= '0;
		repeat (6) @(posedge clk_sys_i);
		@(negedge clk_sys_i) chk(xo, WORD_ONES);
		op(k, m);
		chk(xo, e);
	endtask
	function automatic logic [23:0] ld_exp(input logic [23:0] s, input logic [2:0] m);
		logic [7:0] b;
		b = s >> (8 * ((m + 3) % 4));
		if (m == MOD_FULL) return s;
		if (m == MOD_ADDR) return {9'h0, s[14:0]};
		return m[2] ? {16'h0, b} : {{16{b[7]}}, b};
	endfunction
	function automatic logic [23:0] st_exp(input logic [23:0] z, v, input logic [2:0] m);
		if (m == MOD_FULL) return v;
		if (m == MOD_ADDR) return {z[23:15], v[14:0]};
		if (m[1:0] == 2'h1) return {z[23:8], v[7:0]};
		if (m[1:0] == 2'h2) return {z[23:16], v[7:0], z[7:0]};
		return {v[7:0], z[15:0]};
	endfunction
	initial begin
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		pre_we <= 1'b0;
		for (int m = 0; m < 8; m++)
			ld(11, m[2:0], ld_exp(pre.storage, m[2:0]));
		ld(12, 3'h0, {9'h0, pre.addr});
		ld(10, 3'h0, pre.shift_reg);
		ld(8, 3'h0, {17'h0, pre.input_word});
		ld(9, 3'h0, pre.accum);
		x = pre.accum & pre.shift_reg;
		op(7, 3'h0);
		chk(xo, x);
		$display("test loads done");
		for (int i = 1; i < 9; i++) begin
			@(negedge clk_sys_i) zv = src.storage;
			op(6, i[2:0]);
			chk(so, st_exp(zv, x, i[2:0]));
			chk({23'h0, swe}, 24'h1);
		end
		op(3, 3'h0);
		chk({17'h0, oo}, {17'h0, x[6:0]});
		chk({23'h0, ow}, 24'h1);
		op(5, 3'h0);
		chk({9'h0, ao}, {9'h0, x[14:0]});
		chk({23'h0, aw}, 24'h1);
		op(4, 3'h0);
		chk(sh, x);
		chk({23'h0, shw}, 24'h1);
		chk(bo, x);
		$display("test stores done");
		@(posedge clk_sys_i) ctrl.buffer_set <= 1'b1;
		@(posedge clk_sys_i) ctrl <= xrd_ctrl_t'(13'h1);
		@(posedge clk_sys_i) ctrl <= xrd_ctrl_t'(13'h4);
		@(negedge clk_sys_i) chk({23'h0, avld}, 24'h1);
		@(posedge clk_sys_i) ctrl <= '0;
		@(negedge clk_sys_i) chk(bo, ~x);
		chk(add, ~x);
		chk(xo, x);
		$display("test complement done");
		report_and_stop();
	end
	initial begin
		repeat (2000) @(posedge clk_sys_i);
		miscompares++;
		report_and_stop();
	end
endmodule // tb_top
